// File: hw/esseq_pkg.sv
// Constants and carrier types of the EEPROM store sequencer
package esseq_pkg;
   // Register indices; byte address is four times the index
   localparam logic [11:0] IDX_CTRL = 12'hE00;
   localparam logic [11:0] IDX_SAVE = 12'hE02;
   localparam logic [11:0] IDX_STAT = 12'hE04;
   localparam logic [11:0] IDX_PTR = 12'hE05;
   localparam logic [11:0] IDX_SEQ_FIRST = 12'hE17;
   localparam logic [11:0] IDX_CORE_TIMEBASE_BLOCK_INSTR = 12'hE17;
   localparam logic [11:0] IDX_CORE_TIMEBASE_BLOCK_START = 12'hE18;
   localparam logic [11:0] IDX_APPLY_UPDATE_INSTR = 12'hE1A;
   localparam logic [11:0] IDX_TIMEBASE_CAL_INSTR = 12'hE1B;
   localparam logic [11:0] IDX_REF_ONE_BLOCK_INSTR = 12'hE1C;
   localparam logic [11:0] IDX_REF_ONE_BLOCK_START = 12'hE1D;
   localparam logic [11:0] IDX_REF_TWO_BLOCK_INSTR = 12'hE1F;
   localparam logic [11:0] IDX_REF_TWO_BLOCK_START = 12'hE20;
   localparam logic [11:0] IDX_REF_THREE_BLOCK_INSTR = 12'hE22;
   localparam logic [11:0] IDX_REF_THREE_BLOCK_START = 12'hE23;
   localparam logic [11:0] IDX_REF_FOUR_BLOCK_INSTR = 12'hE25;
   localparam logic [11:0] IDX_REF_FOUR_BLOCK_START = 12'hE26;
   localparam int SEQ_LEN = 17;
   // Field positions
   localparam int CTRL_FAST_BIT = 1;
   localparam int SAVE_BIT = 0;
   localparam int STAT_BUSY_BIT = 0;
   // Instruction codes
   localparam logic [7:0] CODE_APPLY_UPDATE = 8'h80;
   localparam logic [7:0] CODE_TIMEBASE_CAL = 8'h91;
   localparam logic [7:0] CODE_FREE_RUN = 8'h98;
   localparam logic [7:0] CODE_DATA_LIMIT = 8'h80;
   // Reset values
   localparam logic [7:0] RST_CORE_TIMEBASE_BLOCK_INSTR = 8'h08;
   localparam logic [15:0] RST_CORE_TIMEBASE_BLOCK_START = 16'h0200;
   localparam logic [7:0] RST_REF_BLOCK_INSTR = 8'h1E;
   localparam logic [15:0] RST_REF_ONE_BLOCK_START = 16'h0300;
   localparam logic [15:0] RST_REF_TWO_BLOCK_START = 16'h0320;
   localparam logic [15:0] RST_REF_THREE_BLOCK_START = 16'h0340;
   localparam logic [15:0] RST_REF_FOUR_BLOCK_START = 16'h0360;
   // Entry 0 in the low byte
   localparam logic [SEQ_LEN*8-1:0] SEQ_RST = {
      RST_REF_FOUR_BLOCK_START[7:0], RST_REF_FOUR_BLOCK_START[15:8], RST_REF_BLOCK_INSTR,
      RST_REF_THREE_BLOCK_START[7:0], RST_REF_THREE_BLOCK_START[15:8], RST_REF_BLOCK_INSTR,
      RST_REF_TWO_BLOCK_START[7:0], RST_REF_TWO_BLOCK_START[15:8], RST_REF_BLOCK_INSTR,
      RST_REF_ONE_BLOCK_START[7:0], RST_REF_ONE_BLOCK_START[15:8], RST_REF_BLOCK_INSTR,
      CODE_TIMEBASE_CAL, CODE_APPLY_UPDATE,
      RST_CORE_TIMEBASE_BLOCK_START[7:0], RST_CORE_TIMEBASE_BLOCK_START[15:8], RST_CORE_TIMEBASE_BLOCK_INSTR};
   // Link timing
   localparam int CLK_HZ = 20000000;
   localparam int LINK_SLOW_HZ = 100000;
   localparam int LINK_FAST_HZ = 400000;
   localparam logic [7:0] LINK_SLOW_DIV = 8'(CLK_HZ / LINK_SLOW_HZ);
   localparam logic [7:0] LINK_FAST_DIV = 8'(CLK_HZ / LINK_FAST_HZ);
   localparam int FIFO_DEPTH = 16;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
   } esseq_byte_s;

   typedef enum logic [2:0] {
      S_IDLE, S_FETCH, S_ADDR_HI, S_ADDR_LO, S_MREQ, S_MWAIT, S_MCAP, S_MPUSH
   } esseq_state_e;
endpackage : esseq_pkg

// File: hw/esseq_top.sv
// EEPROM store sequencer: sequence walker, Avalon-MM registers and output FIFO
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/100ps

module esseq_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Fill side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // Drain side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wptr_r;
   logic [AW-1:0] rptr_r;
   logic [AW:0] count_r;
   wire do_push = in_valid && in_ready;
   wire do_pop = out_valid && out_ready;

   assign in_ready = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign out_data = mem_r[rptr_r];

   always_ff @(posedge clk_sys) begin
      if (do_push) begin
         mem_r[wptr_r] <= in_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wptr_r <= '0;
         rptr_r <= '0;
         count_r <= '0;
      end else begin
         if (do_push) begin
            wptr_r <= (wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + AW'(1);
         end
         if (do_pop) begin
            rptr_r <= (rptr_r == AW'(DEPTH - 1)) ? '0 : rptr_r + AW'(1);
         end
         count_r <= count_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end

   // Queued byte stands until taken; a full queue never overfills
   a_fifo_hold: assert property (@(posedge clk_sys) disable iff (srst)
      out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("queued byte changed before it was taken");
   a_fifo_bound: assert property (@(posedge clk_sys) disable iff (srst)
      count_r <= (AW+1)'(DEPTH))
      else $error("write queue count above its depth");
   a_fifo_count: assert property (@(posedge clk_sys) disable iff (srst)
      do_push && !do_pop |=> count_r == $past(count_r) + (AW+1)'(1))
      else $error("write queue count did not follow a push");
endmodule : esseq_fifo

module esseq_top #(
   parameter int FIFO_WIDTH = 24,
   parameter int FIFO_DEPTH = esseq_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Avalon-MM slave
   input wire logic [13:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Register-map read port, data valid the cycle after map_rd
   output logic [15:0] map_addr,
   output logic map_rd,
   input wire logic [7:0] map_data,
   // EEPROM byte stream to the serial writer
   output logic [15:0] ee_addr,
   output logic [7:0] ee_data,
   output logic ee_valid,
   input wire logic ee_ready,
   // Serial link bit-period count
   output logic [7:0] link_div
);
   logic [7:0] seq_r [esseq_pkg::SEQ_LEN];
   esseq_pkg::esseq_state_e state_r;
   logic [4:0] idx_r;
   logic [7:0] cnt_r;
   logic [7:0] hi_r;
   logic [7:0] byte_r;
   logic [15:0] map_addr_r;
   logic map_rd_r;
   logic [15:0] ptr_r;
   logic fast_r;
   logic [7:0] link_div_r;
   logic waitreq_r;
   logic [31:0] rdata_r;
   logic [15:0] addr_ptr_r;

   function automatic logic is_single(input logic [7:0] code);
      return code >= esseq_pkg::CODE_DATA_LIMIT;
   endfunction : is_single

   // Register decode
   wire [11:0] reg_idx = avs_address[13:2];
   wire [11:0] seq_off = reg_idx - esseq_pkg::IDX_SEQ_FIRST;
   wire seq_hit = (reg_idx >= esseq_pkg::IDX_SEQ_FIRST) && (seq_off < 12'(esseq_pkg::SEQ_LEN));
   wire busy = (state_r != esseq_pkg::S_IDLE);
   wire wr_take = avs_write && !waitreq_r && avs_byteenable[0];
   // Sequence bytes are frozen while the walker runs
   wire seq_wr = wr_take && seq_hit && !busy;
   wire save_wr = wr_take && (reg_idx == esseq_pkg::IDX_SAVE) && avs_writedata[esseq_pkg::SAVE_BIT];
   wire ctrl_wr = wr_take && (reg_idx == esseq_pkg::IDX_CTRL);
   wire [7:0] seq_rd = seq_r[seq_off[4:0]];
   wire [31:0] rd_mux =
      seq_hit ? {24'h000000, seq_rd} :
      (reg_idx == esseq_pkg::IDX_CTRL) ? {30'h00000000, fast_r, 1'b0} :
      (reg_idx == esseq_pkg::IDX_SAVE) ? {31'h00000000, busy} :
      (reg_idx == esseq_pkg::IDX_STAT) ? {31'h00000000, busy} :
      (reg_idx == esseq_pkg::IDX_PTR) ? {16'h0000, ptr_r} : 32'h00000000;

   // Walker datapath
   wire idx_end = (idx_r >= 5'(esseq_pkg::SEQ_LEN));
   wire [7:0] cur_seq = idx_end ? 8'h00 : seq_r[idx_r];
   wire push_v = ((state_r == esseq_pkg::S_FETCH) && !idx_end) ||
                 (state_r == esseq_pkg::S_ADDR_HI) || (state_r == esseq_pkg::S_ADDR_LO) ||
                 (state_r == esseq_pkg::S_MPUSH);
   wire [7:0] push_byte = (state_r == esseq_pkg::S_MPUSH) ? byte_r : cur_seq;
   wire fifo_in_ready;
   wire push_ok = push_v && fifo_in_ready;
   esseq_pkg::esseq_byte_s push_word;
   esseq_pkg::esseq_byte_s out_word;
   wire out_valid;
   assign push_word = '{addr: ptr_r, data: push_byte};

   esseq_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .srst(srst),
      .in_data(push_word),
      .in_valid(push_v),
      .in_ready(fifo_in_ready),
      .out_data(out_word),
      .out_valid(out_valid),
      .out_ready(ee_ready)
   );

   assign ee_addr = out_word.addr;
   assign ee_data = out_word.data;
   assign ee_valid = out_valid;
   assign map_addr = map_addr_r;
   assign map_rd = map_rd_r;
   assign link_div = link_div_r;
   assign avs_readdata = rdata_r;
   assign avs_waitrequest = waitreq_r;

   // One wait state: read data is loaded while waitrequest is still high
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         waitreq_r <= 1'b1;
         rdata_r <= 32'h00000000;
      end else begin
         waitreq_r <= !((avs_read || avs_write) && waitreq_r);
         if (avs_read && waitreq_r) begin
            rdata_r <= rd_mux;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         for (int i = 0; i < esseq_pkg::SEQ_LEN; i++) begin
            seq_r[i] <= esseq_pkg::SEQ_RST[i*8 +: 8];
         end
      end else if (seq_wr) begin
         seq_r[seq_off[4:0]] <= avs_writedata[7:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         fast_r <= 1'b0;
         link_div_r <= esseq_pkg::LINK_SLOW_DIV;
      end else begin
         if (ctrl_wr) begin
            fast_r <= avs_writedata[esseq_pkg::CTRL_FAST_BIT];
         end
         link_div_r <= fast_r ? esseq_pkg::LINK_FAST_DIV : esseq_pkg::LINK_SLOW_DIV;
      end
   end

   // Pointer clears on a save while idle; otherwise it moves only when a byte enters the write queue
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ptr_r <= 16'h0000;
      end else if (save_wr && !busy) begin
         ptr_r <= 16'h0000;
      end else if (push_ok) begin
         ptr_r <= ptr_r + 16'h0001;
      end
   end

   // Pointer at the high address byte; only the two-byte step check reads it
   // The low byte may wait on a full queue, so a fixed depth of history will not do
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         addr_ptr_r <= 16'h0000;
      end else if ((state_r == esseq_pkg::S_ADDR_HI) && push_ok) begin
         addr_ptr_r <= ptr_r;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_r <= esseq_pkg::S_IDLE;
         idx_r <= '0;
         cnt_r <= 8'h00;
         hi_r <= 8'h00;
         byte_r <= 8'h00;
         map_addr_r <= 16'h0000;
         map_rd_r <= 1'b0;
      end else begin
         map_rd_r <= (state_r == esseq_pkg::S_MREQ);
         unique case (state_r)
            esseq_pkg::S_IDLE: begin
               if (save_wr) begin
                  idx_r <= '0;
                  state_r <= esseq_pkg::S_FETCH;
               end
            end
            esseq_pkg::S_FETCH: begin
               // Save bit reads back busy, so leaving here clears it
               if (idx_end) begin
                  state_r <= esseq_pkg::S_IDLE;
               end else if (push_ok) begin
                  idx_r <= idx_r + 5'h01;
                  if (!is_single(cur_seq)) begin
                     cnt_r <= cur_seq;
                     state_r <= esseq_pkg::S_ADDR_HI;
                  end
               end
            end
            esseq_pkg::S_ADDR_HI: begin
               if (push_ok) begin
                  hi_r <= cur_seq;
                  idx_r <= idx_r + 5'h01;
                  state_r <= esseq_pkg::S_ADDR_LO;
               end
            end
            esseq_pkg::S_ADDR_LO: begin
               if (push_ok) begin
                  map_addr_r <= {hi_r, cur_seq};
                  idx_r <= idx_r + 5'h01;
                  state_r <= esseq_pkg::S_MREQ;
               end
            end
            esseq_pkg::S_MREQ: begin
               state_r <= esseq_pkg::S_MWAIT;
            end
            esseq_pkg::S_MWAIT: begin
               state_r <= esseq_pkg::S_MCAP;
            end
            esseq_pkg::S_MCAP: begin
               byte_r <= map_data;
               state_r <= esseq_pkg::S_MPUSH;
            end
            esseq_pkg::S_MPUSH: begin
               if (push_ok) begin
                  if (cnt_r == 8'h00) begin
                     state_r <= esseq_pkg::S_FETCH;
                  end else begin
                     cnt_r <= cnt_r - 8'h01;
                     map_addr_r <= map_addr_r + 16'h0001;
                     state_r <= esseq_pkg::S_MREQ;
                  end
               end
            end
         endcase
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   a_data_length: assert property ((state_r == esseq_pkg::S_FETCH) && push_ok && !is_single(cur_seq)
      |=> (state_r == esseq_pkg::S_ADDR_HI) && (cnt_r == $past(cur_seq)))
      else $error("data instruction length not captured");
   a_start_addr: assert property ((state_r == esseq_pkg::S_ADDR_LO) && push_ok
      |=> map_addr_r == {$past(hi_r), $past(cur_seq)})
      else $error("start address not formed from the two entries");
   a_ptr_step: assert property (push_ok |=> ptr_r == $past(ptr_r) + 16'h0001)
      else $error("pointer did not advance by one");
   a_addr_bytes: assert property ((state_r == esseq_pkg::S_ADDR_LO) && push_ok
      |=> ptr_r == addr_ptr_r + 16'h0002)
      else $error("pointer not advanced by two over address bytes");
   a_map_read: assert property ((state_r == esseq_pkg::S_MREQ) |=> map_rd_r ##1 !map_rd_r ##1
      (state_r == esseq_pkg::S_MPUSH) && (byte_r == $past(map_data)))
      else $error("map byte not fetched in sequence");
   a_update_code: assert property ((state_r == esseq_pkg::S_FETCH) && push_ok
      && (cur_seq == esseq_pkg::CODE_APPLY_UPDATE) |=> state_r == esseq_pkg::S_FETCH)
      else $error("apply-update code not handled as one byte");
   a_cal_code: assert property ((state_r == esseq_pkg::S_FETCH) && push_ok
      && (cur_seq == esseq_pkg::CODE_TIMEBASE_CAL) |=> state_r == esseq_pkg::S_FETCH)
      else $error("calibrate code not handled as one byte");
   a_free_run: assert property ((state_r == esseq_pkg::S_FETCH) && push_ok
      && (cur_seq == esseq_pkg::CODE_FREE_RUN) |=> (state_r == esseq_pkg::S_FETCH) && $changed(idx_r))
      else $error("free-run code not handled as one byte");
   a_run_end: assert property ((state_r == esseq_pkg::S_MPUSH) && push_ok && (cnt_r == 8'h00)
      |=> state_r == esseq_pkg::S_FETCH)
      else $error("data run did not end at the count");
   a_save_start: assert property (save_wr && !busy |=> busy && (idx_r == 5'h00) && (ptr_r == 16'h0000))
      else $error("save did not start the sequence");
   a_link_rate: assert property ($rose(fast_r) |=> link_div_r == esseq_pkg::LINK_FAST_DIV)
      else $error("fast link rate not selected");
   a_seq_order: assert property ((state_r == esseq_pkg::S_FETCH) && push_ok
      |=> idx_r == $past(idx_r) + 5'h01)
      else $error("sequence not walked in ascending order");

   // Pointer, stall, map port and bus timing
   a_ptr_hold: assert property (!push_ok && !(save_wr && !busy) |=> $stable(ptr_r))
      else $error("pointer moved without a queued byte");
   a_first_byte: assert property (save_wr && !busy |=> push_v && (push_word.addr == 16'h0000))
      else $error("first byte not queued at pointer zero");
   a_push_hold: assert property (push_v && !push_ok |=> push_v && $stable(push_word))
      else $error("offered byte changed while the queue was full");
   a_fetch_hold: assert property ((state_r == esseq_pkg::S_FETCH) && !idx_end && !push_ok
      |=> (state_r == esseq_pkg::S_FETCH) && $stable(idx_r))
      else $error("entry skipped while the queue was full");
   a_hi_capture: assert property ((state_r == esseq_pkg::S_ADDR_HI) && push_ok
      |=> (state_r == esseq_pkg::S_ADDR_LO) && (hi_r == $past(cur_seq)))
      else $error("start address high byte not captured");
   a_map_step: assert property ((state_r == esseq_pkg::S_MPUSH) && push_ok && (cnt_r != 8'h00)
      |=> map_addr_r == $past(map_addr_r) + 16'h0001)
      else $error("map address did not step by one");
   a_map_pulse: assert property (map_rd_r |-> state_r == esseq_pkg::S_MWAIT)
      else $error("map strobe outside its slot");
   a_busy_end: assert property ((state_r == esseq_pkg::S_FETCH) && idx_end
      |=> state_r == esseq_pkg::S_IDLE)
      else $error("walker did not stop after the last entry");
   a_save_clear: assert property ((reg_idx == esseq_pkg::IDX_SAVE) && !busy
      |-> rd_mux == 32'h00000000)
      else $error("save bit did not read back clear when idle");
   a_seq_frozen: assert property (wr_take && seq_hit && busy
      |=> seq_r[$past(seq_off[4:0])] == $past(seq_rd))
      else $error("sequence entry changed while walking");
   a_link_slow: assert property ($fell(fast_r) |=> link_div_r == esseq_pkg::LINK_SLOW_DIV)
      else $error("slow link rate not restored");
   a_bus_wait: assert property ((avs_read || avs_write) && waitreq_r |=> !waitreq_r ##1 waitreq_r)
      else $error("register access did not get one wait state");
endmodule : esseq_top

// File: verification/esseq_far_model.sv
// Far-side model: register-map byte source and EEPROM byte sink
`timescale 1ns/100ps
module esseq_far_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Bench control
   input wire logic stall,
   input wire logic clr,
   output logic [15:0] rx_cnt,
   output logic addr_bad,
   // Register-map port
   input wire logic [15:0] map_addr,
   input wire logic map_rd,
   output logic [7:0] map_data,
   // EEPROM byte stream
   input wire logic [15:0] ee_addr,
   input wire logic [7:0] ee_data,
   input wire logic ee_valid,
   output logic ee_ready
);
   logic [7:0] mem [0:255];
   logic [5:0] tick_r;
   // Stalled sink takes one byte in 64 cycles, so the FIFO fills up
   assign ee_ready = !stall || (tick_r == 6'h00);
   always_ff @(posedge clk_sys) begin
      tick_r <= tick_r + 6'h01;
      // Map byte valid only in the cycle after the strobe; it toggles otherwise
      if (srst) begin
         map_data <= 8'hA5;
      end else if (map_rd) begin
         map_data <= map_addr[7:0] ^ map_addr[15:8] ^ 8'h5A;
      end else begin
         map_data <= ~map_data;
      end
      if (srst || clr) begin
         rx_cnt <= 16'h0000;
         addr_bad <= 1'h0;
         tick_r <= 6'h01;
      end else if (ee_valid && ee_ready) begin
         mem[ee_addr[7:0]] <= ee_data;
         rx_cnt <= rx_cnt + 16'h0001;
         if (ee_addr != rx_cnt) begin
            addr_bad <= 1'h1;
         end
      end
   end
endmodule : esseq_far_model

// File: verification/tb_top.sv
// Self-checking bench for the EEPROM store sequencer
`timescale 1ns/100ps
module tb_top;
   logic clk_sys;
   logic srst;
   logic [13:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [15:0] map_addr;
   logic map_rd;
   logic [7:0] map_data;
   logic [15:0] ee_addr;
   logic [7:0] ee_data;
   logic ee_valid;
   logic ee_ready;
   logic [7:0] link_div;
   logic stall;
   logic clr;
   logic [15:0] rx_cnt;
   logic addr_bad;
   int err_total = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [31:0] rdat;
   logic [7:0] seq [0:16];
   logic [7:0] exp_q [$];
   // Register index beside the value it should read after reset
   logic [19:0] rows [0:21] = '{
      {12'hE17, 8'h08}, {12'hE18, 8'h02}, {12'hE19, 8'h00}, {12'hE1A, 8'h80}, {12'hE1B, 8'h91}, {12'hE1C, 8'h1E},
      {12'hE1D, 8'h03}, {12'hE1E, 8'h00}, {12'hE1F, 8'h1E}, {12'hE20, 8'h03}, {12'hE21, 8'h20}, {12'hE22, 8'h1E},
      {12'hE23, 8'h03}, {12'hE24, 8'h40}, {12'hE25, 8'h1E}, {12'hE26, 8'h03}, {12'hE27, 8'h60},
      {12'hE00, 8'h00}, {12'hE02, 8'h00}, {12'hE04, 8'h00}, {12'hE05, 8'h00}, {12'hE30, 8'h00}};

   esseq_top DUT (.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .map_addr(map_addr), .map_rd(map_rd),
      .map_data(map_data), .ee_addr(ee_addr), .ee_data(ee_data), .ee_valid(ee_valid), .ee_ready(ee_ready),
      .link_div(link_div));
   esseq_far_model far (.clk_sys(clk_sys), .srst(srst), .stall(stall), .clr(clr), .rx_cnt(rx_cnt),
      .addr_bad(addr_bad), .map_addr(map_addr), .map_rd(map_rd), .map_data(map_data), .ee_addr(ee_addr),
      .ee_data(ee_data), .ee_valid(ee_valid), .ee_ready(ee_ready));

   initial begin
      clk_sys = 1'h0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : conclude

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Holds the request until waitrequest is seen low, then lets an edge pass
   task automatic av(input logic rd, input logic [11:0] idx, input logic [7:0] wd);
      avs_address <= {idx, 2'h0};
      avs_read <= rd;
      avs_write <= !rd;
      avs_writedata <= {24'h000000, wd};
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'h0) @(posedge clk_sys);
      rdat = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      @(posedge clk_sys);
   endtask : av

   function automatic logic [7:0] map_byte(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction : map_byte

   task automatic build;
      int i;
      logic [15:0] a;
      exp_q.delete();
      i = 0;
      while (i < 17) begin
         exp_q.push_back(seq[i]);
         if (seq[i] < 8'h80) begin
            a = {seq[i+1], seq[i+2]};
            exp_q.push_back(seq[i+1]);
            exp_q.push_back(seq[i+2]);
            for (int k = 0; k <= seq[i]; k++) exp_q.push_back(map_byte(a + 16'(k)));
            i += 2;
         end
         i++;
      end
   endtask : build

   task automatic save_run(input logic st);
      int n;
      build();
      stall <= st;
      clr <= 1'h1;
      @(posedge clk_sys);
      clr <= 1'h0;
      av(1'h0, 12'hE02, 8'h01);
      av(1'h1, 12'hE04, 8'h00);
      chk(rdat, 32'h00000001);
      av(1'h0, 12'hE17, 8'h55);
      n = 0;
      rdat = 32'h00000001;
      while (rdat[0] !== 1'h0 && n < 20000) begin
         av(1'h1, 12'hE02, 8'h00);
         n++;
      end
      chk(rdat, 32'h00000000);
      n = 0;
      while (ee_valid !== 1'h0 && n < 2000) begin
         @(posedge clk_sys);
         n++;
      end
      chk(32'(rx_cnt), exp_q.size());
      for (int j = 0; j < exp_q.size(); j++) chk(32'(far.mem[j]), 32'(exp_q[j]));
      chk(32'(addr_bad), 32'h00000000);
      av(1'h1, 12'hE05, 8'h00);
      chk(rdat, exp_q.size());
      av(1'h1, 12'hE17, 8'h00);
      chk(rdat, 32'(seq[0]));
   endtask : save_run

   initial begin
      srst = 1'h1;
      avs_address = 14'h0000;
      avs_read = 1'h0;
      avs_write = 1'h0;
      avs_byteenable = 4'hF;
      avs_writedata = 32'h00000000;
      stall = 1'h0;
      clr = 1'h0;
      repeat (4) @(posedge clk_sys);
      srst <= 1'h0;
      @(posedge clk_sys);
      chk(32'(link_div), 32'h000000C8);
      for (int r = 0; r < 22; r++) begin
         av(1'h1, rows[r][19:8], 8'h00);
         chk(rdat, 32'(rows[r][7:0]));
      end
      $display("test register defaults done");
      // Divider follows the fast bit one cycle later
      av(1'h0, 12'hE00, 8'h02);
      @(posedge clk_sys);
      chk(32'(link_div), 32'h00000032);
      av(1'h0, 12'hE00, 8'h00);
      @(posedge clk_sys);
      chk(32'(link_div), 32'h000000C8);
      $display("test link rate done");
      for (int i = 0; i < 17; i++) seq[i] = rows[i][7:0];
      save_run(1'h1);
      $display("test default sequence with stalls done");
      seq[0] = 8'h98;
      seq[1] = 8'h00;
      seq[2] = 8'h12;
      seq[3] = 8'h34;
      seq[4] = 8'h91;
      for (int i = 0; i < 5; i++) av(1'h0, 12'hE17 + 12'(i), seq[i]);
      save_run(1'h0);
      $display("test edited sequence done");
      // Write with lane 0 disabled must be dropped
      avs_byteenable <= 4'hE;
      av(1'h0, 12'hE18, 8'h77);
      avs_byteenable <= 4'hF;
      av(1'h1, 12'hE18, 8'h00);
      chk(rdat, 32'(seq[1]));
      $display("test lane-gated write done");
      // Reset in the middle of a save
      av(1'h0, 12'hE02, 8'h01);
      repeat (30) @(posedge clk_sys);
      srst <= 1'h1;
      repeat (4) @(posedge clk_sys);
      srst <= 1'h0;
      @(posedge clk_sys);
      chk(32'(ee_valid), 32'h00000000);
      chk(32'(avs_waitrequest), 32'h00000001);
      chk(32'(map_rd), 32'h00000000);
      chk(32'(link_div), 32'h000000C8);
      av(1'h1, 12'hE04, 8'h00);
      chk(rdat, 32'h00000000);
      av(1'h1, 12'hE05, 8'h00);
      chk(rdat, 32'h00000000);
      av(1'h1, 12'hE17, 8'h00);
      chk(rdat, 32'h00000008);
      $display("test reset in mid-run done");
      conclude();
   end
endmodule : tb_top
